// *** design/ltm_map.svh ***
// register map, field positions and timing counts of the loop transceiver master port.
// assumes inclusion by the port module and by the bench top module; definitions only.
`ifndef LTM_MAP_SVH
`define LTM_MAP_SVH

`define LTM_ADDR_CTRL        32'h0000_0000
`define LTM_ADDR_STATUS      32'h0000_0004
`define LTM_ADDR_TXWORD      32'h0000_0008
`define LTM_ADDR_RXFIELD     32'h0000_000c

`define LTM_CTRL_PD_N        0
`define LTM_CTRL_LB_N        1
`define LTM_CTRL_SI1         2
`define LTM_CTRL_SI2         3
`define LTM_CTRL_SIE         4
`define LTM_CTRL_SE          5
`define LTM_CTRL_RESET       6'h00

`define LTM_ST_ACTIVE        0
`define LTM_ST_LOOP          1
`define LTM_ST_VALID         2
`define LTM_ST_SO1           3
`define LTM_ST_SO2           4

`define LTM_WAKE_EDGES       2'h3
`define LTM_IDLE_EDGES       2'h3
`define LTM_BITS             4'h8
`define LTM_NINTH            4'h9
`define LTM_FIELD_SIG1       8
`define LTM_FIELD_SIG2       9
`define LTM_CONV_DIV         8'h08

`define LTM_RESP_OKAY        2'h0
`define LTM_RESP_SLVERR      2'h2

`endif

// *** design/ltm_pkg.sv ***
// types shared by the loop transceiver master port.
// assumes ltm_map.svh supplies the numeric constants.
package ltm_pkg;

	typedef struct packed {
		logic       sig_2;
		logic       sig_1;
		logic [7:0] voice;
	} ltm_field_t;

	typedef struct packed {
		logic       strobe;
		logic       good;
		ltm_field_t field;
	} ltm_demod_t;

	typedef enum logic [1:0] {
		LTM_PWR_DOWN = 2'b00,
		LTM_PWR_WAIT = 2'b01,
		LTM_PWR_RUN  = 2'b10
	} ltm_pwr_t;

endpackage : ltm_pkg

// *** design/ltm_port.sv ***
// master-side digital control of a burst-mode loop transceiver, with an axi4-lite slave.
// assumes all pins synchronous to clk; the modem sits outside and talks via demod/mod strobes.
// Contract
// - loopback isolates line input and parks drivers
// - loopback level latched while bus share low
// - loopback only acts while powered up
// - valid only for synced error-free burst
// - powered up, valid updates on frame sync
// - powered down, valid drops after three idle syncs
// - valid high impedance while bus share low
// - signaling inputs sampled on frame sync rise
// - signaling outputs update like valid flag
// - signaling outputs high impedance while share low
// - share low latches control pins internally
// - powered down stops transmission, keeps receive
// - wake after three syncs or demod end
// - frame sync moves words and starts modulation
// - insert mode puts received sig2 in pcm lsb
// - insert mode sends captured pcm lsb as sig2
// - insert mode forces sent voice lsb zero
// - eight voice bits follow send enable rise
// - send enable drives pcm output enable
// - late frame sync loads word at ninth bit
// - eight receive bits on recv clock falls
// - frame sync moves received word to buffer
// - burst field orders voice and two sig bits
//
// Local design decisions: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "ltm_map.svh"

module ltm_port #(
	parameter int BITS = 8
) (
	input  wire logic               clk,               // 100 MHz system clock
	input  wire logic               rst_n,             // async active-low reset
	input  wire logic [31:0]        s_axi_awaddr,      // write address
	input  wire logic               s_axi_awvalid,     // write address valid
	output logic                    s_axi_awready,     // write address ready
	input  wire logic [31:0]        s_axi_wdata,       // write data
	input  wire logic [3:0]         s_axi_wstrb,       // write byte enables
	input  wire logic               s_axi_wvalid,      // write data valid
	output logic                    s_axi_wready,      // write data ready
	output logic [1:0]              s_axi_bresp,       // write response
	output logic                    s_axi_bvalid,      // write response valid
	input  wire logic               s_axi_bready,      // write response ready
	input  wire logic [31:0]        s_axi_araddr,      // read address
	input  wire logic               s_axi_arvalid,     // read address valid
	output logic                    s_axi_arready,     // read address ready
	output logic [31:0]             s_axi_rdata,       // read data
	output logic [1:0]              s_axi_rresp,       // read response
	output logic                    s_axi_rvalid,      // read data valid
	input  wire logic               s_axi_rready,      // read data ready
	input  wire logic               frame_sync,        // frame sync pin
	input  wire logic               send_bit_clock,    // send bit clock pin
	input  wire logic               recv_bit_clock,    // receive bit clock pin
	input  wire logic               send_word_enable,  // send enable pin
	input  wire logic               recv_word_enable,  // receive enable pin
	input  wire logic               pcm_in,            // pcm data in
	output logic                    pcm_out_o,         // pcm data out
	output logic                    pcm_out_oe,        // pcm output enable
	input  wire logic               convert_clock,     // convert clock pin
	output logic                    conv_tick,         // divided convert clock tick
	input  wire logic               power_down_n,      // power-down pin, low = down
	input  wire logic               loopback_n,        // loopback pin, low = loop
	input  wire logic               sig_in_1,          // signaling in 1
	input  wire logic               sig_in_2,          // signaling in 2
	input  wire logic               sig_insert_en,     // signal insert enable
	input  wire logic               bus_share_enable,  // shared-bus enable
	output logic                    sig_out_1_o,       // signaling out 1
	output logic                    sig_out_2_o,       // signaling out 2
	output logic                    valid_frame_o,     // valid frame
	output logic                    shared_oe,         // enable for sig_out and valid_frame
	input  wire logic               wire_receive_input,// line receive sample from modem
	output logic                    demod_in,          // line sample routed to demodulator
	input  wire logic               mod_out,           // modulator output sample
	output logic                    wire_drive_park,   // drivers held at reference
	input  wire ltm_pkg::ltm_demod_t demod,            // demodulation complete strobe
	output logic                    mod_start,         // modulation start pulse
	output ltm_pkg::ltm_field_t     mod_field          // outgoing burst field
);

	// control register: software copies of the pins; signaling and insert bits or-ed in, power-down, loopback and share bits and-ed in
	logic [5:0]          ctrl_r;
	logic                fs_d_r, sbc_d_r, rbc_d_r, swe_d_r, rwe_d_r, cc_d_r;
	logic                fs_rise, sbc_rise, rbc_fall, swe_rise, rwe_rise, cc_rise;
	logic                pd_n_l_r, lb_n_l_r, si1_l_r, si2_l_r;
	logic                pd_n_eff, lb_n_eff, si1_eff, si2_eff, sie_eff, se_eff, loop_on;
	ltm_pkg::ltm_pwr_t   pwr_r;
	logic [1:0]          wake_cnt_r, idle_cnt_r;
	logic [BITS-1:0]     rx_sh_r, tx_sh_r;
	logic [3:0]          rx_cnt_r, tx_cnt_r;
	logic                tx_busy_r, load_pend_r;
	ltm_pkg::ltm_field_t rx_buf_r;
	logic                rx_good_r, rx_new_r;
	logic                so1_r, so2_r, vf_r;
	logic [7:0]          cc_cnt_r;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fs_d_r  <= 1'b0;
			sbc_d_r <= 1'b0;
			rbc_d_r <= 1'b0;
			swe_d_r <= 1'b0;
			rwe_d_r <= 1'b0;
			cc_d_r  <= 1'b0;
		end else begin
			fs_d_r  <= frame_sync;
			sbc_d_r <= send_bit_clock;
			rbc_d_r <= recv_bit_clock;
			swe_d_r <= send_word_enable;
			rwe_d_r <= recv_word_enable;
			cc_d_r  <= convert_clock;
		end
	end
	assign fs_rise  = frame_sync & ~fs_d_r;
	assign sbc_rise = send_bit_clock & ~sbc_d_r;
	assign rbc_fall = ~recv_bit_clock & rbc_d_r;
	assign swe_rise = send_word_enable & ~swe_d_r;
	assign rwe_rise = recv_word_enable & ~rwe_d_r;
	assign cc_rise  = convert_clock & ~cc_d_r;
	// convert clock divided down for internal timing
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cc_cnt_r  <= 8'h00;
			conv_tick <= 1'b0;
		end else begin
			conv_tick <= 1'b0;
			if (cc_rise) begin
				if (cc_cnt_r == `LTM_CONV_DIV - 8'h01) begin
					cc_cnt_r  <= 8'h00;
					conv_tick <= 1'b1;
				end else begin
					cc_cnt_r <= cc_cnt_r + 8'h01;
				end
			end
		end
	end

	// effective control levels; software bits can also force states
	assign se_eff = bus_share_enable & ctrl_r[`LTM_CTRL_SE];
	assign sie_eff = sig_insert_en | ctrl_r[`LTM_CTRL_SIE];
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pd_n_l_r <= 1'b0;
			lb_n_l_r <= 1'b1;
			si1_l_r  <= 1'b0;
			si2_l_r  <= 1'b0;
		end else if (se_eff) begin
			pd_n_l_r <= power_down_n & ctrl_r[`LTM_CTRL_PD_N];
			lb_n_l_r <= loopback_n & ctrl_r[`LTM_CTRL_LB_N];
			si1_l_r  <= sig_in_1 | ctrl_r[`LTM_CTRL_SI1];
			si2_l_r  <= sig_in_2 | ctrl_r[`LTM_CTRL_SI2];
		end
	end

	assign pd_n_eff = se_eff ? (power_down_n & ctrl_r[`LTM_CTRL_PD_N]) : pd_n_l_r;
	assign lb_n_eff = se_eff ? (loopback_n & ctrl_r[`LTM_CTRL_LB_N]) : lb_n_l_r;
	assign si1_eff  = se_eff ? (sig_in_1 | ctrl_r[`LTM_CTRL_SI1]) : si1_l_r;
	assign si2_eff  = se_eff ? (sig_in_2 | ctrl_r[`LTM_CTRL_SI2]) : si2_l_r;
	assign loop_on  = ~lb_n_eff & pd_n_eff;
	assign demod_in        = loop_on ? mod_out : wire_receive_input;
	assign wire_drive_park = loop_on | (pwr_r != ltm_pkg::LTM_PWR_RUN);
	// power sequencing
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pwr_r      <= ltm_pkg::LTM_PWR_DOWN;
			wake_cnt_r <= 2'h0;
		end else begin
			case (pwr_r)
				ltm_pkg::LTM_PWR_DOWN: begin
					wake_cnt_r <= 2'h0;
					if (pd_n_eff)
						pwr_r <= ltm_pkg::LTM_PWR_WAIT;
				end
				ltm_pkg::LTM_PWR_WAIT: begin
					if (!pd_n_eff)
						pwr_r <= ltm_pkg::LTM_PWR_DOWN;
					else if (demod.strobe || (fs_rise && wake_cnt_r == `LTM_WAKE_EDGES - 2'h1))
						pwr_r <= ltm_pkg::LTM_PWR_RUN;
					else if (fs_rise)
						wake_cnt_r <= wake_cnt_r + 2'h1;
				end
				ltm_pkg::LTM_PWR_RUN: begin
					if (!pd_n_eff)
						pwr_r <= ltm_pkg::LTM_PWR_DOWN;
				end
				default: pwr_r <= ltm_pkg::LTM_PWR_DOWN;
			endcase
		end
	end

	// receive capture: eight falling recv clock edges after enable rise
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_sh_r  <= '0;
			rx_cnt_r <= 4'h0;
		end else if (rwe_rise) begin
			rx_cnt_r <= `LTM_BITS;
		end else if (rbc_fall && rx_cnt_r != 4'h0) begin
			rx_sh_r  <= {rx_sh_r[BITS-2:0], pcm_in};
			rx_cnt_r <= rx_cnt_r - 4'h1;
		end
	end

	// burst buffer build and modulation start on frame sync when running
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mod_start <= 1'b0;
			mod_field <= '0;
		end else begin
			mod_start <= 1'b0;
			if (fs_rise && pwr_r == ltm_pkg::LTM_PWR_RUN) begin
				mod_start       <= 1'b1;
				mod_field.voice <= {rx_sh_r[BITS-1:1], rx_sh_r[0] & ~sie_eff};
				mod_field.sig_1 <= si1_eff;
				mod_field.sig_2 <= sie_eff ? rx_sh_r[0] : si2_eff;
			end
		end
	end

	// received burst hold
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_buf_r  <= '0;
			rx_good_r <= 1'b0;
			rx_new_r  <= 1'b0;
		end else if (demod.strobe) begin
			rx_buf_r  <= demod.field;
			rx_good_r <= demod.good;
			rx_new_r  <= 1'b1;
		end else if (fs_rise) begin
			rx_new_r  <= 1'b0;
		end
	end

	// signaling and valid outputs
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			so1_r      <= 1'b0;
			so2_r      <= 1'b0;
			vf_r       <= 1'b0;
			idle_cnt_r <= 2'h0;
		end else if (pd_n_eff) begin
			idle_cnt_r <= 2'h0;
			if (fs_rise) begin
				so1_r <= rx_buf_r.sig_1;
				so2_r <= rx_buf_r.sig_2;
				vf_r  <= rx_good_r & rx_new_r;
			end
		end else if (demod.strobe) begin
			so1_r      <= demod.field.sig_1;
			so2_r      <= demod.field.sig_2;
			vf_r       <= demod.good;
			idle_cnt_r <= 2'h0;
		end else if (fs_rise) begin
			if (idle_cnt_r == `LTM_IDLE_EDGES - 2'h1)
				vf_r <= 1'b0;
			else
				idle_cnt_r <= idle_cnt_r + 2'h1;
		end
	end

	assign sig_out_1_o   = so1_r;
	assign sig_out_2_o   = so2_r;
	assign valid_frame_o = vf_r;
	assign shared_oe     = se_eff;
	// send shifter; a load at a late frame sync waits for the ninth send bit clock
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_sh_r     <= '0;
			tx_cnt_r    <= 4'h0;
			tx_busy_r   <= 1'b0;
			load_pend_r <= 1'b0;
			pcm_out_o   <= 1'b0;
		end else begin
			if (swe_rise) begin
				tx_busy_r <= 1'b1;
				tx_cnt_r  <= 4'h0;
			end else if (sbc_rise && tx_busy_r) begin
				tx_cnt_r <= tx_cnt_r + 4'h1;
				if (tx_cnt_r < `LTM_BITS) begin
					pcm_out_o <= tx_sh_r[BITS-1];
					tx_sh_r   <= {tx_sh_r[BITS-2:0], 1'b0};
				end
				if (tx_cnt_r + 4'h1 == `LTM_NINTH) begin
					tx_busy_r <= 1'b0;
					if (load_pend_r || fs_rise) begin
						tx_sh_r     <= {rx_buf_r.voice[BITS-1:1],
							sie_eff ? rx_buf_r.sig_2 : rx_buf_r.voice[0]};
						load_pend_r <= 1'b0;
					end
				end
			end
			if (fs_rise) begin
				if (tx_busy_r && tx_cnt_r < `LTM_BITS)
					load_pend_r <= 1'b1;
				else
					tx_sh_r <= {rx_buf_r.voice[BITS-1:1],
						sie_eff ? rx_buf_r.sig_2 : rx_buf_r.voice[0]};
			end
		end
	end

	assign pcm_out_oe = send_word_enable;
	// axi4-lite slave: aw and w taken together, answer one cycle later
	logic wr_go, rd_go;
	logic [31:0] rd_val;
	assign wr_go         = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
	assign s_axi_awready = wr_go;
	assign s_axi_wready  = wr_go;
	assign rd_go         = s_axi_arvalid & ~s_axi_rvalid;
	assign s_axi_arready = rd_go;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r       <= `LTM_CTRL_RESET;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `LTM_RESP_OKAY;
		end else begin
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= `LTM_RESP_OKAY;
				if (s_axi_awaddr == `LTM_ADDR_CTRL) begin
					if (s_axi_wstrb[0])
						ctrl_r <= s_axi_wdata[5:0];
				end else if (s_axi_awaddr != `LTM_ADDR_STATUS &&
				             s_axi_awaddr != `LTM_ADDR_TXWORD &&
				             s_axi_awaddr != `LTM_ADDR_RXFIELD) begin
					s_axi_bresp <= `LTM_RESP_SLVERR;
				end
			end
		end
	end

	always_comb begin
		rd_val = 32'h0000_0000;
		case (s_axi_araddr)
			`LTM_ADDR_CTRL:    rd_val = {26'h0, ctrl_r};
			`LTM_ADDR_STATUS:  rd_val = {27'h0, so2_r, so1_r, vf_r, loop_on,
			                             pwr_r == ltm_pkg::LTM_PWR_RUN};
			`LTM_ADDR_TXWORD:  rd_val = {22'h0, mod_field};
			`LTM_ADDR_RXFIELD: rd_val = {21'h0, rx_good_r, rx_buf_r};
			default:           rd_val = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= `LTM_RESP_OKAY;
		end else begin
			if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
			if (rd_go) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_val;
				s_axi_rresp  <= (s_axi_araddr == `LTM_ADDR_CTRL ||
				                 s_axi_araddr == `LTM_ADDR_STATUS ||
				                 s_axi_araddr == `LTM_ADDR_TXWORD ||
				                 s_axi_araddr == `LTM_ADDR_RXFIELD) ?
				                `LTM_RESP_OKAY : `LTM_RESP_SLVERR;
			end
		end
	end

endmodule : ltm_port

// *** tb/ltm_port_sva.sv ***
// concurrent checks on the loop transceiver master port pins.
// assumes it sees only ltm_port ports and that all pins are synchronous to clk.
`timescale 1ns/1ps
module ltm_port_sva (
	input wire logic                clk,                // clock
	input wire logic                rst_n,              // reset, low active
	input wire logic                frame_sync,         // sync pin
	input wire logic                send_bit_clock,     // send clock pin
	input wire logic                send_word_enable,   // send enable pin
	input wire logic                power_down_n,       // power pin
	input wire logic                sig_insert_en,      // insert pin
	input wire logic                bus_share_enable,   // share pin
	input wire logic                pcm_out_o,          // pcm data
	input wire logic                pcm_out_oe,         // pcm enable
	input wire logic                sig_out_1_o,        // signaling out 1
	input wire logic                valid_frame_o,      // valid flag
	input wire logic                shared_oe,          // shared enable
	input wire logic                wire_receive_input, // line sample
	input wire logic                demod_in,           // demod feed
	input wire logic                wire_drive_park,    // drivers parked
	input wire ltm_pkg::ltm_demod_t demod,              // demod result
	input wire logic                mod_start,          // burst start
	input wire ltm_pkg::ltm_field_t mod_field           // burst field
);
	logic       fs_q, sb_q, se_q, last_good;
	logic [3:0] since_fs, since_sb, since_dm;
	logic [1:0] fs_idle;
	function automatic logic [3:0] inc(input logic [3:0] v);
		return v + {3'h0, v != 4'hf};
	endfunction : inc
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			{fs_q, sb_q, se_q, last_good} <= 4'h0;
			{since_fs, since_sb, since_dm} <= 12'hfff;
			fs_idle <= 2'h0;
		end else begin
			{fs_q, sb_q, se_q} <= {frame_sync, send_bit_clock, send_word_enable};
			since_fs <= (frame_sync && !fs_q) ? 4'h0 : inc(since_fs);
			since_sb <= ((send_bit_clock && !sb_q) || (send_word_enable && !se_q)) ? 4'h0
				: inc(since_sb);
			since_dm <= demod.strobe ? 4'h0 : inc(since_dm);
			if (demod.strobe)
				fs_idle <= 2'h0;
			else if (frame_sync && !fs_q && fs_idle != 2'h3)
				fs_idle <= fs_idle + 2'h1;
			if (demod.strobe)
				last_good <= demod.good;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_after_sync;
		(since_fs <= 4'h3) ##1 !mod_start;
	endsequence
	a_send_oe: assert property (pcm_out_oe == send_word_enable)
		else $error("pcm enable does not follow send enable");
	a_share_off: assert property (!bus_share_enable |-> !shared_oe)
		else $error("shared outputs driven while bus share low");
	a_line_route: assert property (!wire_drive_park |-> demod_in == wire_receive_input)
		else $error("line input not routed to demodulator");
	a_burst_pulse: assert property (mod_start |-> s_after_sync)
		else $error("burst start not a single pulse after frame sync");
	a_down_quiet: assert property ((!power_down_n && shared_oe) [*6] |-> !mod_start)
		else $error("burst started while powered down");
	a_valid_good: assert property ($rose(valid_frame_o) |-> last_good)
		else $error("valid raised without a good burst");
	a_flag_timing: assert property (($changed(valid_frame_o) || $changed(sig_out_1_o))
		|-> (since_fs <= 4'h4 || since_dm <= 4'h4))
		else $error("flag changed away from sync or demod end");
	a_idle_drop: assert property (fs_idle == 2'h3 |-> ##[0:4] !valid_frame_o)
		else $error("valid held after three idle syncs");
	a_pcm_timing: assert property ($changed(pcm_out_o) |-> (since_sb <= 4'h4 || since_fs <= 4'h4))
		else $error("pcm bit changed away from send clock rise");
	a_insert_lsb: assert property (mod_start && $past(sig_insert_en)
		|-> mod_field.voice[0] == 1'b0)
		else $error("voice lsb not cleared in insert mode");
endmodule : ltm_port_sva
bind ltm_port ltm_port_sva i_sva (.*);

// *** tb/ltm_slave_model.sv ***
// behavioural remote slave and modem: answers each burst after a set delay.
// assumes the bench sets reply, good and delay; field and flag are garbage outside strobes.
`timescale 1ns/1ps
module ltm_slave_model (
	input  wire logic                clk,       // clock
	input  wire logic                rst_n,     // reset, low active
	input  wire logic                mod_start, // burst request
	input  wire ltm_pkg::ltm_field_t mod_field, // burst field
	input  wire logic [7:0]          delay,     // reply latency in cycles
	input  wire ltm_pkg::ltm_field_t reply,     // reply field
	input  wire logic                good,      // reply sync and error flag
	input  wire logic                kick,      // unsolicited burst
	output ltm_pkg::ltm_demod_t      demod,     // demod result
	output ltm_pkg::ltm_field_t      sent       // last burst seen
);
	logic [7:0] cnt;
	logic       fire;
	assign fire = kick || (cnt == 8'h01);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt   <= 8'h00;
			sent  <= '0;
			demod <= '0;
		end else begin
			demod.strobe <= fire;
			demod.good   <= fire ? good : !good;
			demod.field  <= fire ? reply : ~reply;
			if (mod_start) begin
				sent <= mod_field;
				cnt  <= delay;
			end else if (cnt != 8'h00)
				cnt <= cnt - 8'h01;
		end
	end
endmodule : ltm_slave_model

// *** tb/loop_transceiver_master_port_tb_top.sv ***
// self-checking bench for the loop transceiver master port.
// assumes ltm_port, its checker and the slave model are compiled before it.
`timescale 1ns/1ps
`include "ltm_map.svh"
module loop_transceiver_master_port_tb_top;
	logic        clk, rst_n, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, frame_sync, send_bit_clock, recv_bit_clock;
	logic        send_word_enable, recv_word_enable, pcm_in, pcm_out_o, pcm_out_oe;
	logic        convert_clock, conv_tick, power_down_n, loopback_n, sig_in_1, sig_in_2;
	logic        sig_insert_en, bus_share_enable, sig_out_1_o, sig_out_2_o, valid_frame_o;
	logic        shared_oe, wire_receive_input, demod_in, mod_out, wire_drive_park;
	logic        mod_start, kick, good;
	ltm_pkg::ltm_demod_t demod;
	ltm_pkg::ltm_field_t mod_field, reply, sent;
	logic [7:0]  tx;
	logic [16:0] cv_acc;
	int          bad_count, compares, cyc, mods, cc_rises;
	ltm_port i_dut (.*);
	ltm_slave_model i_slave (.clk(clk), .rst_n(rst_n), .mod_start(mod_start),
		.mod_field(mod_field), .delay(8'h05), .reply(reply), .good(good), .kick(kick),
		.demod(demod), .sent(sent));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (mod_start === 1'b1)
			mods <= mods + 1;
		if (cv_acc + 17'h01000 >= 17'h186a0) begin
			cv_acc        <= cv_acc + 17'h01000 - 17'h186a0;
			convert_clock <= !convert_clock;
			cc_rises      <= cc_rises + {31'h0, !convert_clock};
		end else
			cv_acc <= cv_acc + 17'h01000;
		if (cyc == 32'h0000_4e20) begin
			bad_count++;
			end_sim();
		end
	end
	task automatic end_sim();
		if (bad_count == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_sim
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic chk1(input string nm, input logic e, input logic g);
		chk(nm, {31'h0, e}, {31'h0, g});
	endtask : chk1
	task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
		{s_axi_awaddr, s_axi_wdata} <= {a, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do begin
			@(posedge clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				s_axi_bready <= 1'b0;
				r = s_axi_bresp;
			end
		end while (s_axi_awvalid || s_axi_wvalid || s_axi_bready);
	endtask : axi_wr
	task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do begin
			@(posedge clk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				s_axi_rready <= 1'b0;
				d = s_axi_rdata;
				r = s_axi_rresp;
			end
		end while (s_axi_arvalid || s_axi_rready);
	endtask : axi_rd
	task automatic t_conv();
		int n;
		while (conv_tick !== 1'b1)
			tick(1);
		n = cc_rises;
		tick(1);
		while (conv_tick !== 1'b1)
			tick(1);
		chk("conv_div", {24'h0, `LTM_CONV_DIV}, cc_rises - n);
	endtask : t_conv
	task automatic frame(input logic [7:0] rx);
		frame_sync <= 1'b1;
		tick(2);
		frame_sync <= 1'b0;
		{recv_word_enable, send_word_enable} <= 2'h3;
		tick(2);
		for (int i = 7; i >= 0; i--) begin
			pcm_in <= rx[i];
			{send_bit_clock, recv_bit_clock} <= 2'h3;
			tick(3);
			tx[i] = pcm_out_o;
			{send_bit_clock, recv_bit_clock} <= 2'h0;
			tick(3);
		end
		{recv_word_enable, send_word_enable} <= 2'h0;
		tick(4);
	endtask : frame
	task automatic t_regs();
		logic [31:0] d;
		logic [1:0]  r;
		axi_rd(`LTM_ADDR_CTRL, d, r);
		chk("ctrl_reset", 32'h0, d);
		axi_rd(32'h0000_0010, d, r);
		chk("unmapped_resp", {30'h0, `LTM_RESP_SLVERR}, {30'h0, r});
		axi_wr(`LTM_ADDR_CTRL, 32'h0000_0023, r);
		chk("wr_resp", {30'h0, `LTM_RESP_OKAY}, {30'h0, r});
		axi_wr(32'h0000_0010, 32'h0000_0000, r);
		chk("wr_unmapped", {30'h0, `LTM_RESP_SLVERR}, {30'h0, r});
		axi_rd(`LTM_ADDR_CTRL, d, r);
		chk("ctrl_rw", 32'h23, d);
	endtask : t_regs
	task automatic t_wake();
		int n;
		{power_down_n, sig_in_1, sig_in_2} <= 3'h6;
		tick(4);
		n = mods;
		frame(8'h5a);
		frame(8'h11);
		frame(8'hc3);
		chk("wake_wait", n, mods);
		frame(8'h00);
		chk("first_burst", n + 1, mods);
		chk("burst_field", 32'h1c3, {22'h0, sent});
	endtask : t_wake
	task automatic t_return();
		{reply, good} <= {10'h23c, 1'b1};
		frame(8'h00);
		frame(8'h00);
		chk("tx_word", 32'h3c, {24'h0, tx});
		chk1("so1", 1'b0, sig_out_1_o);
		chk1("so2", 1'b1, sig_out_2_o);
		chk1("valid_good", 1'b1, valid_frame_o);
		good <= 1'b0;
		frame(8'h00);
		frame(8'h00);
		chk1("valid_bad", 1'b0, valid_frame_o);
	endtask : t_return
	task automatic t_insert();
		{sig_insert_en, sig_in_2, good, reply} <= {3'h5, 10'h0ff};
		frame(8'h81);
		frame(8'h00);
		chk("insert_field", 32'h380, {22'h0, sent});
		chk("insert_tx", 32'hfe, {24'h0, tx});
		sig_insert_en <= 1'b0;
	endtask : t_insert
	task automatic t_loop();
		int n;
		{loopback_n, mod_out, wire_receive_input} <= 3'h2;
		tick(4);
		chk1("loop_route", 1'b1, demod_in);
		chk1("loop_park", 1'b1, wire_drive_park);
		bus_share_enable <= 1'b0;
		tick(3);
		chk1("share_oe", 1'b0, shared_oe);
		{loopback_n, power_down_n} <= 2'h2;
		n = mods;
		frame(8'h00);
		chk1("loop_latched", 1'b1, demod_in);
		chk("pd_latched", n + 1, mods);
		power_down_n <= 1'b1;
		tick(2);
		bus_share_enable <= 1'b1;
		tick(4);
		chk1("loop_off", 1'b0, demod_in);
		chk1("park_off", 1'b0, wire_drive_park);
	endtask : t_loop
	task automatic t_down();
		int n;
		{power_down_n, loopback_n, mod_out, wire_receive_input} <= 4'h2;
		{reply, good} <= {10'h100, 1'b1};
		tick(4);
		chk1("down_no_loop", 1'b0, demod_in);
		loopback_n <= 1'b1;
		n = mods;
		kick <= 1'b1;
		tick(1);
		kick <= 1'b0;
		tick(4);
		chk1("down_so1", 1'b1, sig_out_1_o);
		chk1("down_valid", 1'b1, valid_frame_o);
		frame(8'h00);
		frame(8'h00);
		chk1("valid_hold", 1'b1, valid_frame_o);
		frame(8'h00);
		chk1("valid_drop", 1'b0, valid_frame_o);
		chk("down_quiet", n, mods);
	endtask : t_down
	initial begin
		{rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = {96'h0, 4'hf};
		{frame_sync, send_bit_clock, recv_bit_clock, send_word_enable} = 4'h0;
		{recv_word_enable, pcm_in, convert_clock, power_down_n, loopback_n} = 5'h1;
		{sig_in_1, sig_in_2, sig_insert_en, bus_share_enable} = 4'h1;
		{wire_receive_input, mod_out, kick, good, reply} = {4'h1, 10'h000};
		{bad_count, compares, cyc, mods, cc_rises, cv_acc} = {160'h0, 17'h0};
		tick(2);
		rst_n <= 1'b1;
		tick(1);
		t_regs();
		t_wake();
		t_return();
		t_insert();
		t_loop();
		t_down();
		t_conv();
		end_sim();
	end
endmodule : loop_transceiver_master_port_tb_top
